// ### bench/eeprom_slave_bench.sv
// Self-checking bench for the two-wire byte memory slave
`timescale 1ns/100ps
module eeprom_slave_bench;
    localparam logic [3:0] DEV = 4'h5; // Arbitrary device code
    localparam int WCYC = 400;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic write_protect = 1'b0;
    logic supply_low = 1'b0;
    logic scl, sda_drv, sda_o, sda_oe_n, write_busy, sda_line;
    int fails = 0;
    int total_checks = 0;
    int cyc = 0;
    logic [7:0] mem_exp [0:2047];
    always #50 clk = ~clk;
    // Pull-up wins unless someone pulls low
    assign sda_line = sda_drv & (sda_oe_n | sda_o);
    eeprom_slave #(.DEV_CODE(DEV), .WRITE_CYCLES(16'(WCYC))) i_dut (
        .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_line),
        .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .write_protect(write_protect), .supply_low(supply_low),
        .write_busy(write_busy));
    i2c_master_model i_mst (.clk(clk), .sda_line(sda_line), .scl(scl),
        .sda_drv(sda_drv));
    // ----
    // Compare and closing tasks
    // ----
    task automatic chk_bit(input logic got, input logic exp, string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s", $time, m);
        end
    endtask
    task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp,
            string m);
        total_checks++;
        if (got !== exp) begin
            fails++;
            $display("MISMATCH %0t %s %h %h", $time, m, got, exp);
        end
    endtask
    task automatic end_sim();
        $display("checks %0d mismatches %0d", total_checks, fails);
        if (fails == 0 && total_checks > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 80000) begin
            fails++;
            end_sim();
        end
    end
    // ----
    // Transfer helpers
    // ----
    task automatic load_addr(input logic [10:0] a);
        logic ak;
        i_mst.start_c();
        i_mst.send_byte({DEV, 3'h0, 1'b0}, ak);
        chk_bit(ak, 1'b1, "device ack");
        i_mst.send_byte({5'h00, a[10:8]}, ak);
        chk_bit(ak, 1'b1, "addr hi ack");
        i_mst.send_byte(a[7:0], ak);
        chk_bit(ak, 1'b1, "addr lo ack");
    endtask
    // ok tells whether the stop should start a write cycle
    task automatic write_page(input logic [10:0] a, input int n,
            input logic [7:0] d0, input logic ok);
        logic ak;
        logic seen;
        load_addr(a);
        for (int k = 0; k < n; k++) begin
            i_mst.send_byte(d0 + 8'(k), ak);
            chk_bit(ak, 1'b1, "data ack");
            if (ok) mem_exp[{a[10:4], a[3:0] + 4'(k)}] = d0 + 8'(k);
        end
        i_mst.stop_c();
        seen = 1'b0;
        repeat (20) begin
            @(posedge clk);
            seen = seen | write_busy;
        end
        chk_bit(seen, ok, "write cycle start");
    endtask
    task automatic wait_idle();
        int n;
        n = 0;
        while (write_busy !== 1'b0 && n < WCYC + 100) begin
            @(posedge clk);
            n++;
        end
        chk_bit(write_busy, 1'b0, "write cycle end");
    endtask
    task automatic read_check(input logic [10:0] a, input int n);
        logic ak;
        logic [7:0] d;
        load_addr(a);
        i_mst.start_c();
        i_mst.send_byte({DEV, 3'h0, 1'b1}, ak);
        chk_bit(ak, 1'b1, "read ack");
        for (int k = 0; k < n; k++) begin
            i_mst.recv_byte(k == n - 1, d);
            chk_byte(d, mem_exp[a + 11'(k)], "read data");
        end
        i_mst.stop_c();
    endtask
    // ----
    // Scenarios
    // ----
    task automatic t_reset();
        chk_bit(sda_oe_n, 1'b1, "released after reset");
        chk_bit(write_busy, 1'b0, "idle after reset");
        chk_bit(sda_o, 1'b0, "drive value low");
    endtask
    // 18 bytes from column 14 wrap and overwrite, under clock spikes
    task automatic t_page();
        logic ak;
        i_mst.glitch <= 1'b1;
        write_page(11'h12E, 18, 8'hA0, 1'b1);
        i_mst.start_c();
        i_mst.send_byte({DEV, 3'h0, 1'b0}, ak);
        chk_bit(ak, 1'b0, "poll while busy");
        i_mst.stop_c();
        i_mst.glitch <= 1'b0;
        wait_idle();
        read_check(11'h120, 16);
    endtask
    task automatic t_block();
        for (int c = 0; c < 2; c++) begin
            write_protect <= (c == 0);
            supply_low <= (c == 1);
            @(posedge clk);
            write_page(11'h125, 1, 8'h55, 1'b0);
            read_check(11'h120, 8);
        end
        write_protect <= 1'b0;
        supply_low <= 1'b0;
    endtask
    task automatic t_wrap();
        write_page(11'h7FF, 1, 8'h3C, 1'b1);
        wait_idle();
        write_page(11'h000, 1, 8'hC3, 1'b1);
        wait_idle();
        read_check(11'h7FF, 2);
    endtask
    initial begin
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        repeat (8) @(posedge clk);
        t_reset();
        t_page();
        t_block();
        t_wrap();
        end_sim();
    end
endmodule

// ### bench/i2c_master_model.sv
// Two-wire bus master model: serial clock and open-drain data
`timescale 1ns/100ps
module i2c_master_model (
    input wire logic clk,      // Bench clock
    input wire logic sda_line, // Resolved data line
    output logic scl,          // Serial clock
    output logic sda_drv       // 0 pulls low, 1 releases
);
    logic glitch = 1'b0;
    initial begin
        scl = 1'b1;
        sda_drv = 1'b1;
    end
    // ----
    // Bit and frame tasks
    // ----
    // 13 low and 12 high cycles: 2.5 us, the fastest legal rate
    task automatic bit_io(input logic b, output logic s);
        repeat (4) @(posedge clk);
        sda_drv <= b;
        repeat (4) @(posedge clk);
        if (glitch) begin
            // One-cycle spike that a real edge must never mimic
            scl <= 1'b1;
            @(posedge clk);
            scl <= 1'b0;
        end
        repeat (5) @(posedge clk);
        scl <= 1'b1;
        repeat (3) @(posedge clk);
        if (glitch) begin
            // Data spike with clock high would fake a start or stop
            sda_drv <= ~b;
        end
        @(posedge clk);
        sda_drv <= b;
        repeat (2) @(posedge clk);
        @(negedge clk) s = sda_line;
        repeat (6) @(posedge clk);
        scl <= 1'b0;
    endtask
    // Waits first so data never moves together with the clock fall
    task automatic start_c();
        repeat (4) @(posedge clk);
        sda_drv <= 1'b1;
        repeat (10) @(posedge clk);
        scl <= 1'b1;
        repeat (8) @(posedge clk);
        sda_drv <= 1'b0;
        repeat (8) @(posedge clk);
        scl <= 1'b0;
    endtask
    task automatic stop_c();
        repeat (4) @(posedge clk);
        sda_drv <= 1'b0;
        repeat (8) @(posedge clk);
        scl <= 1'b1;
        repeat (8) @(posedge clk);
        sda_drv <= 1'b1;
        repeat (14) @(posedge clk);
    endtask
    task automatic send_byte(input logic [7:0] b, output logic acked);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(b[i], s);
        bit_io(1'b1, s);
        acked = ~s;
    endtask
    task automatic recv_byte(input logic nack, output logic [7:0] d);
        logic s;
        for (int i = 7; i >= 0; i--) bit_io(1'b1, d[i]);
        bit_io(nack, s);
    endtask
endmodule

// ### core/byte_fifo2.sv
// Two-entry byte buffer with valid and ready on both sides
`timescale 1ns/100ps

module byte_fifo2 (
    input wire logic clk,                      // System clock
    input wire logic rst,                      // Synchronous reset
    input wire eeprom_pkg::byte_beat_t in_beat, // Incoming byte
    output logic in_ready,                     // Space for a byte
    output eeprom_pkg::byte_beat_t out_beat,   // Oldest byte
    input wire logic out_ready                 // Consumer takes byte
);

    eeprom_pkg::fifo_t r;
    eeprom_pkg::fifo_t n;
    logic push;
    logic pop;

    assign in_ready = (r.cnt != 2'h2);
    assign out_beat.valid = (r.cnt != 2'h0);
    assign out_beat.data = r.data[r.rd];
    assign push = in_beat.valid && in_ready;
    assign pop = out_beat.valid && out_ready;

    always_comb begin
        n = r;
        if (push) begin
            n.data[r.wr] = in_beat.data;
            n.wr = ~r.wr;
        end
        if (pop) begin
            n.rd = ~r.rd;
        end
        if (push && !pop) begin
            n.cnt = r.cnt + 2'h1;
        end else if (pop && !push) begin
            n.cnt = r.cnt - 2'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

endmodule

// ### core/eeprom_pkg.sv
// Shared constants and carrier types for the serial byte memory slave
package eeprom_pkg;

    // ----------------------------------------------------------------
    // Timing
    // ----------------------------------------------------------------
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SPIKE_NS = 100;
    // Least stability time: round up to whole cycles
    localparam int unsigned SPIKE_CYC =
        (SPIKE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned WRITE_TIME_MS = 5;
    // Longest time: round down to whole cycles
    localparam int unsigned WRITE_CYC =
        (WRITE_TIME_MS * 1000000) / CLK_PERIOD_NS;

    // ----------------------------------------------------------------
    // Geometry and field positions
    // ----------------------------------------------------------------
    localparam int unsigned DATA_W = 8;
    localparam int unsigned ADDR_W = 11;
    localparam int unsigned MEM_DEPTH = 2048;
    localparam int unsigned PAGE_BYTES = 16;
    localparam int unsigned BITS_PER_BYTE = 8;
    localparam int unsigned PIN_SDA = 0;
    localparam int unsigned PIN_SCL = 1;
    localparam int unsigned DIR_BIT = 0;

    // ----------------------------------------------------------------
    // Types
    // ----------------------------------------------------------------
    typedef enum logic [6:0] {
        ST_IDLE  = 7'h01,
        ST_DEV   = 7'h02,
        ST_AHI   = 7'h04,
        ST_ALO   = 7'h08,
        ST_WDATA = 7'h10,
        ST_RDATA = 7'h20,
        ST_BUSY  = 7'h40
    } phase_t;

    typedef struct packed {
        logic valid;
        logic [DATA_W-1:0] data;
    } byte_beat_t;

    typedef struct packed {
        logic [2:0] sync;
        logic [1:0] cnt;
        logic filt;
        logic prev;
    } pin_state_t;

    localparam pin_state_t PIN_RESET = '{
        sync: 3'h7, cnt: 2'h0, filt: 1'b1, prev: 1'b1};

    typedef struct packed {
        logic [1:0][DATA_W-1:0] data;
        logic [1:0] cnt;
        logic wr;
        logic rd;
    } fifo_t;

    typedef struct packed {
        phase_t st;
        logic [3:0] bitcnt;
        logic ack;
        logic mack;
        logic sda_low;
        logic [DATA_W-1:0] shreg;
        logic [ADDR_W-1:0] addr;
        logic [PAGE_BYTES-1:0] pmask;
        logic [PAGE_BYTES-1:0][DATA_W-1:0] page;
        logic [15:0] wcnt;
        pin_state_t [1:0] pin;
    } core_t;

endpackage

// ### core/eeprom_slave.sv
// Two-wire slave front end with page write and 2k x 8 byte storage
`timescale 1ns/100ps

module eeprom_slave #(
    // Arbitrary value, not that of any real part
    parameter logic [3:0] DEV_CODE = 4'h5,
    parameter logic [15:0] WRITE_CYCLES = 16'(eeprom_pkg::WRITE_CYC)
) (
    input wire logic clk,           // System clock, 10 MHz
    input wire logic rst,           // Synchronous reset, active high
    input wire logic scl_i,         // Serial clock from master
    input wire logic sda_i,         // Data line level
    output logic sda_o,             // Data drive value, always low
    output logic sda_oe_n,          // Low while pulling data low
    input wire logic write_protect, // High blocks write cycle start
    input wire logic supply_low,    // High blocks write cycle start
    output logic write_busy         // Internal write cycle running
);

    // ----------------------------------------------------------------
    // State and storage
    // ----------------------------------------------------------------
    eeprom_pkg::core_t r;
    eeprom_pkg::core_t n;
    eeprom_pkg::pin_state_t pin_next [2];
    logic [eeprom_pkg::DATA_W-1:0] mem [eeprom_pkg::MEM_DEPTH];
    logic [1:0] pin_raw;
    logic scl;
    logic sda;
    logic scl_rise;
    logic scl_fall;
    logic start_ev;
    logic stop_ev;
    logic byte_done;
    logic mem_we;
    logic [3:0] widx;
    logic [eeprom_pkg::DATA_W-1:0] mem_rd;
    eeprom_pkg::byte_beat_t fifo_in;
    eeprom_pkg::byte_beat_t fifo_out;
    logic fifo_in_ready;
    logic fifo_out_ready;

    // ----------------------------------------------------------------
    // Input synchronisers and spike filters
    // ----------------------------------------------------------------
    assign pin_raw = {scl_i, sda_i};

    for (genvar g = 0; g < 2; g++) begin : g_pin
        // A level must hold past the spike time before it is believed
        always_comb begin
            pin_next[g] = r.pin[g];
            pin_next[g].sync = {r.pin[g].sync[1:0], pin_raw[g]};
            pin_next[g].prev = r.pin[g].filt;
            if (r.pin[g].sync[1] != r.pin[g].sync[2]) begin
                pin_next[g].cnt = 2'h0;
            end else if (r.pin[g].sync[2] != r.pin[g].filt) begin
                if (r.pin[g].cnt == 2'(eeprom_pkg::SPIKE_CYC)) begin
                    pin_next[g].filt = r.pin[g].sync[2];
                    pin_next[g].cnt = 2'h0;
                end else begin
                    pin_next[g].cnt = r.pin[g].cnt + 2'h1;
                end
            end else begin
                pin_next[g].cnt = 2'h0;
            end
        end
    end

    assign scl = r.pin[eeprom_pkg::PIN_SCL].filt;
    assign sda = r.pin[eeprom_pkg::PIN_SDA].filt;
    // Edges come from filtered levels only, with no timeout, so any serial
    // rate down to a stopped clock is followed
    assign scl_rise = scl && !r.pin[eeprom_pkg::PIN_SCL].prev;
    assign scl_fall = !scl && r.pin[eeprom_pkg::PIN_SCL].prev;
    assign start_ev = scl && r.pin[eeprom_pkg::PIN_SCL].prev &&
        !sda && r.pin[eeprom_pkg::PIN_SDA].prev;
    assign stop_ev = scl && r.pin[eeprom_pkg::PIN_SCL].prev &&
        sda && !r.pin[eeprom_pkg::PIN_SDA].prev;

    // ----------------------------------------------------------------
    // Page data buffer
    // ----------------------------------------------------------------
    assign byte_done = scl_fall && !r.ack &&
        (r.bitcnt == 4'(eeprom_pkg::BITS_PER_BYTE));
    assign fifo_in.valid = byte_done && (r.st == eeprom_pkg::ST_WDATA);
    assign fifo_in.data = r.shreg;
    // Page latch stops taking bytes once the write cycle owns it
    assign fifo_out_ready = (r.st != eeprom_pkg::ST_BUSY);

    byte_fifo2 u_fifo (
        .clk(clk),
        .rst(rst),
        .in_beat(fifo_in),
        .in_ready(fifo_in_ready),
        .out_beat(fifo_out),
        .out_ready(fifo_out_ready)
    );

    // ----------------------------------------------------------------
    // Storage array
    // ----------------------------------------------------------------
    assign mem_rd = mem[r.addr];
    assign widx = r.wcnt[3:0];
    // One page byte per cycle at the start of the write cycle
    assign mem_we = (r.st == eeprom_pkg::ST_BUSY) &&
        (r.wcnt < 16'(eeprom_pkg::PAGE_BYTES)) && r.pmask[widx];

    always_ff @(posedge clk) begin
        if (mem_we) begin
            mem[{r.addr[10:4], widx}] <= r.page[widx];
        end
    end

    // ----------------------------------------------------------------
    // Protocol engine
    // ----------------------------------------------------------------
    always_comb begin
        n = r;
        n.pin[0] = pin_next[0];
        n.pin[1] = pin_next[1];
        if (fifo_out.valid && fifo_out_ready) begin
            n.page[r.addr[3:0]] = fifo_out.data;
            n.pmask[r.addr[3:0]] = 1'b1;
            n.addr[3:0] = r.addr[3:0] + 4'h1;
        end
        case (r.st)
            eeprom_pkg::ST_BUSY: begin
                // Bus is deaf here, so polling masters see no ack
                n.sda_low = 1'b0;
                if (r.wcnt == WRITE_CYCLES - 16'h1) begin
                    n.st = eeprom_pkg::ST_IDLE;
                    n.wcnt = 16'h0;
                    n.pmask = '0;
                end else begin
                    n.wcnt = r.wcnt + 16'h1;
                end
            end
            default: begin
                if (start_ev) begin
                    n.st = eeprom_pkg::ST_DEV;
                    n.bitcnt = 4'h0;
                    n.ack = 1'b0;
                    n.sda_low = 1'b0;
                    n.pmask = '0;
                end else if (stop_ev) begin
                    n.sda_low = 1'b0;
                    n.ack = 1'b0;
                    n.st = eeprom_pkg::ST_IDLE;
                    if (r.st == eeprom_pkg::ST_WDATA && r.pmask != '0 &&
                        !write_protect && !supply_low) begin
                        n.st = eeprom_pkg::ST_BUSY;
                        n.wcnt = 16'h0;
                    end else begin
                        n.pmask = '0;
                    end
                end else if (r.st != eeprom_pkg::ST_IDLE) begin
                    if (scl_rise) begin
                        if (r.ack) begin
                            n.mack = !sda;
                        end else begin
                            n.bitcnt = r.bitcnt + 4'h1;
                            n.shreg = {r.shreg[6:0], sda};
                        end
                    end else if (scl_fall && r.ack) begin
                        n.ack = 1'b0;
                        n.sda_low = 1'b0;
                        if (r.st == eeprom_pkg::ST_RDATA) begin
                            if (r.mack) begin
                                n.shreg = mem_rd;
                                n.sda_low = !mem_rd[7];
                                n.addr = r.addr + 11'h1;
                            end else begin
                                n.st = eeprom_pkg::ST_IDLE;
                            end
                        end
                    end else if (byte_done) begin
                        n.bitcnt = 4'h0;
                        n.ack = 1'b1;
                        n.sda_low = 1'b1;
                        if (r.st == eeprom_pkg::ST_DEV) begin
                            if (r.shreg[7:4] != DEV_CODE) begin
                                n.st = eeprom_pkg::ST_IDLE;
                                n.ack = 1'b0;
                                n.sda_low = 1'b0;
                            end else if (r.shreg[eeprom_pkg::DIR_BIT]) begin
                                n.st = eeprom_pkg::ST_RDATA;
                                n.mack = 1'b1;
                            end else begin
                                n.st = eeprom_pkg::ST_AHI;
                            end
                        end else if (r.st == eeprom_pkg::ST_AHI) begin
                            n.addr[10:8] = r.shreg[2:0];
                            n.st = eeprom_pkg::ST_ALO;
                        end else if (r.st == eeprom_pkg::ST_ALO) begin
                            n.addr[7:0] = r.shreg;
                            n.pmask = '0;
                            n.st = eeprom_pkg::ST_WDATA;
                        end else if (r.st == eeprom_pkg::ST_WDATA) begin
                            // A full buffer withholds the ack
                            n.sda_low = fifo_in_ready;
                        end else begin
                            n.sda_low = 1'b0;
                        end
                    end else if (scl_fall &&
                        r.st == eeprom_pkg::ST_RDATA) begin
                        // The rise already shifted, so bit 7 is the next one
                        n.sda_low = !r.shreg[7];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
            r.st <= eeprom_pkg::ST_IDLE;
            r.pin <= {eeprom_pkg::PIN_RESET, eeprom_pkg::PIN_RESET};
        end else begin
            r <= n;
        end
    end

    assign sda_o = 1'b0;
    assign sda_oe_n = !r.sda_low;
    assign write_busy = (r.st == eeprom_pkg::ST_BUSY);

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    protect_block_a: assert property ($rose(write_busy) |->
        $past(!write_protect)) else $error("write cycle under protect");
    write_start_a: assert property ((stop_ev && !write_protect &&
        !supply_low && r.st == eeprom_pkg::ST_WDATA && r.pmask != '0)
        |=> write_busy) else $error("allowed write did not start");
    lowsupply_block_a: assert property (($rose(write_busy)) |->
        $past(!supply_low)) else $error("write cycle under low supply");
    busy_no_ack_a: assert property (write_busy |-> sda_oe_n)
        else $error("ack while write cycle runs");
    busy_length_a: assert property ($fell(write_busy) |->
        $past(r.wcnt) == WRITE_CYCLES - 16'h1)
        else $error("write cycle length wrong");
    drive_edge_a: assert property ($fell(sda_oe_n) |->
        $past(scl_fall)) else $error("data driven off falling edge");
    spike_filter_a: assert property ($changed(scl) |->
        $past(r.pin[eeprom_pkg::PIN_SCL].sync[2], 1) == scl &&
        $past(r.pin[eeprom_pkg::PIN_SCL].sync[2], 2) == scl)
        else $error("short pulse passed filter");
    page_stay_a: assert property ((r.st == eeprom_pkg::ST_WDATA &&
        $past(r.st) == eeprom_pkg::ST_WDATA) |->
        r.addr[10:4] == $past(r.addr[10:4]))
        else $error("page write left its page");
    addr_load_a: assert property ((byte_done &&
        r.st == eeprom_pkg::ST_ALO) |=> r.addr[7:0] == $past(r.shreg) &&
        !sda_oe_n) else $error("word address not loaded and acked");
    read_advance_a: assert property ((scl_fall && r.ack && r.mack &&
        r.st == eeprom_pkg::ST_RDATA) |=> r.addr == $past(r.addr) + 11'h1)
        else $error("read address did not advance");

endmodule
